//--- verilog/tbw_cfg.svh
// constants of the tag block write sequencer
`ifndef TBW_CFG_SVH
`define TBW_CFG_SVH

// command code and argument record layout
`define TBW_CMD_WRITE        8'h03
`define TBW_ARG_BLOCK        4'h0
`define TBW_ARG_COUNT        4'h1
`define TBW_ARG_OFFSET       4'h2
`define TBW_ARG_KEYSEL       4'h3
`define TBW_ARG_KEY          4'h4
`define TBW_ARG_BYTES        11
`define TBW_KEY_USE_BIT      6
`define TBW_KEY_B_BIT        7

// register map, byte wide registers
`define TBW_REG_CMD          9'h000
`define TBW_REG_OUTCOME      9'h001
`define TBW_REG_STATUS       9'h002
`define TBW_REG_IRQ_STAT     9'h003
`define TBW_REG_IRQ_CLR      9'h004
`define TBW_REG_IRQ_EN       9'h005
`define TBW_REG_ARG_BASE     9'h010
`define TBW_REG_ARG_LAST     9'h01a

// outcome codes
`define TBW_OUT_OK           8'h00
`define TBW_OUT_ERR_AUTH     8'h01
`define TBW_OUT_ERR_WRITE    8'h02
`define TBW_OUT_ERR_PARAM    8'h03
`define TBW_OUT_ERR_CMD      8'h04
`define TBW_OUT_BUSY         8'hff

// tag memory geometry
`define TBW_BLOCK_BYTES      16
`define TBW_BUF_BYTES        256
`define TBW_LARGE_SECT_BASE  8'h20

// interrupt bits
`define TBW_IRQ_DONE         0
`define TBW_IRQ_ERR          1

`endif

//--- verilog/tbw_pkg.sv
// types of the tag block write sequencer
package tbw_pkg;

    typedef enum logic [7:0] {
        TBW_IDLE      = 8'h01,
        TBW_AUTH_REQ  = 8'h02,
        TBW_AUTH_WAIT = 8'h04,
        TBW_GATHER    = 8'h08,
        TBW_WR_REQ    = 8'h10,
        TBW_WR_WAIT   = 8'h20,
        TBW_FINISH    = 8'h40,
        TBW_SPARE     = 8'h80
    } tbw_state_e;

    typedef enum logic [1:0] {
        TBW_OP_NONE  = 2'h0,
        TBW_OP_AUTH  = 2'h1,
        TBW_OP_WRITE = 2'h2
    } tbw_op_e;

    typedef struct packed {
        tbw_state_e          state;
        logic [10:0][7:0]    args;
        logic [7:0]          outcome;
        logic [7:0]          blk;
        logic [7:0]          left;
        logic [7:0]          ptr;
        logic                use_key;
        logic [3:0]          gcnt;
        logic [15:0][7:0]    data;
        tbw_op_e             op;
        logic [7:0]          tag_blk;
        logic [47:0]         tag_key;
        logic                tag_key_b;
        logic [1:0]          irq_stat;
        logic [1:0]          irq_en;
        logic [7:0]          rd_data;
    } tbw_regs_s;

endpackage

//--- verilog/tbw_sequencer.sv
// multi-block tag write command sequencer with register port and staging buffer
`include "tbw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tbw_sequencer
    import tbw_pkg::*;
(
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          reset_in,
    // register port
    input  wire logic [8:0]    reg_addr_in,
    input  wire logic [7:0]    reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic      [7:0]    reg_rdata_out,
    // tag engine request
    output logic               tag_req_valid_out,
    input  wire logic          tag_req_ready_in,
    output logic      [1:0]    tag_op_out,
    output logic      [7:0]    tag_block_out,
    output logic      [47:0]   tag_key_out,
    output logic               tag_key_b_out,
    output logic      [127:0]  tag_data_out,
    // tag engine response
    input  wire logic          tag_resp_valid_in,
    input  wire logic          tag_resp_ok_in,
    // status
    output logic               busy_out,
    output logic               irq_out
);

    tbw_regs_s  st_r;
    tbw_regs_s  st_nxt;
    logic [7:0] buf_mem [0:`TBW_BUF_BYTES-1];

    logic       buf_wr;
    logic       cmd_wr;
    logic [7:0] next_blk;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    // sector holding a block: 4-block sectors below 128, 16-block above
    function automatic logic [7:0] sector_of(input logic [7:0] b);
        logic [7:0] s;
        s = b[7] ? (`TBW_LARGE_SECT_BASE | {5'h00, b[6:4]}) : {3'h0, b[6:2]};
        return s;
    endfunction

    assign buf_wr   = reg_wr_in && reg_addr_in[8] && (st_r.state == TBW_IDLE);
    assign cmd_wr   = reg_wr_in && (reg_addr_in == `TBW_REG_CMD);
    assign next_blk = 8'(st_r.blk + 8'h01);

    // staging buffer, written by software only while idle
    always_ff @(posedge clk_in) begin
        if (buf_wr) begin
            buf_mem[reg_addr_in[7:0]] <= reg_wdata_in;
        end
    end

    always_comb begin
        st_nxt  = st_r;
        irq_set = 2'h0;
        irq_clr = 2'h0;

        // register reads answer one cycle later
        st_nxt.rd_data = 8'h00;
        if (reg_rd_in) begin
            if (reg_addr_in[8]) begin
                st_nxt.rd_data = buf_mem[reg_addr_in[7:0]];
            end else if (reg_addr_in >= `TBW_REG_ARG_BASE && reg_addr_in <= `TBW_REG_ARG_LAST) begin
                st_nxt.rd_data = st_r.args[4'(reg_addr_in - `TBW_REG_ARG_BASE)];
            end else begin
                case (reg_addr_in)
                    `TBW_REG_OUTCOME:  st_nxt.rd_data = st_r.outcome;
                    `TBW_REG_STATUS:   st_nxt.rd_data = {7'h00, st_r.state != TBW_IDLE};
                    `TBW_REG_IRQ_STAT: st_nxt.rd_data = {6'h00, st_r.irq_stat};
                    `TBW_REG_IRQ_EN:   st_nxt.rd_data = {6'h00, st_r.irq_en};
                    default:           st_nxt.rd_data = 8'h00;
                endcase
            end
        end

        // argument and interrupt register writes
        if (reg_wr_in && !reg_addr_in[8]) begin
            if (reg_addr_in >= `TBW_REG_ARG_BASE && reg_addr_in <= `TBW_REG_ARG_LAST
                && st_r.state == TBW_IDLE) begin
                st_nxt.args[4'(reg_addr_in - `TBW_REG_ARG_BASE)] = reg_wdata_in;
            end
            if (reg_addr_in == `TBW_REG_IRQ_EN) begin
                st_nxt.irq_en = reg_wdata_in[1:0];
            end
            if (reg_addr_in == `TBW_REG_IRQ_CLR) begin
                irq_clr = reg_wdata_in[1:0];
            end
        end

        case (st_r.state)
            TBW_IDLE: begin
                st_nxt.op = TBW_OP_NONE;
                if (cmd_wr) begin
                    if (reg_wdata_in == `TBW_CMD_WRITE) begin
                        if (st_r.args[`TBW_ARG_COUNT] == 8'h00) begin
                            st_nxt.outcome = `TBW_OUT_ERR_PARAM;
                            irq_set[`TBW_IRQ_ERR] = 1'b1;
                        end else begin
                            st_nxt.blk       = st_r.args[`TBW_ARG_BLOCK];
                            st_nxt.tag_blk   = st_r.args[`TBW_ARG_BLOCK];
                            st_nxt.left      = st_r.args[`TBW_ARG_COUNT];
                            st_nxt.ptr       = st_r.args[`TBW_ARG_OFFSET];
                            st_nxt.use_key   = st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_USE_BIT];
                            st_nxt.tag_key_b = st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_B_BIT];
                            st_nxt.tag_key   = st_r.args[`TBW_ARG_KEY + 4'h5 : `TBW_ARG_KEY];
                            st_nxt.gcnt      = 4'h0;
                            st_nxt.outcome   = `TBW_OUT_BUSY;
                            if (st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_USE_BIT]) begin
                                st_nxt.state = TBW_AUTH_REQ;
                            end else begin
                                st_nxt.state = TBW_GATHER;
                            end
                        end
                    end else begin
                        st_nxt.outcome = `TBW_OUT_ERR_CMD;
                        irq_set[`TBW_IRQ_ERR] = 1'b1;
                    end
                end
            end
            TBW_AUTH_REQ: begin
                st_nxt.op = TBW_OP_AUTH;
                if (tag_req_ready_in) begin
                    st_nxt.state = TBW_AUTH_WAIT;
                end
            end
            TBW_AUTH_WAIT: begin
                if (tag_resp_valid_in) begin
                    if (tag_resp_ok_in) begin
                        st_nxt.state = TBW_GATHER;
                        st_nxt.gcnt  = 4'h0;
                    end else begin
                        st_nxt.outcome = `TBW_OUT_ERR_AUTH;
                        st_nxt.state   = TBW_FINISH;
                    end
                end
            end
            TBW_GATHER: begin
                st_nxt.data[st_r.gcnt] = buf_mem[st_r.ptr];
                st_nxt.ptr  = 8'(st_r.ptr + 8'h01);
                st_nxt.gcnt = 4'(st_r.gcnt + 4'h1);
                if (st_r.gcnt == 4'(`TBW_BLOCK_BYTES - 1)) begin
                    st_nxt.state = TBW_WR_REQ;
                end
            end
            TBW_WR_REQ: begin
                st_nxt.op = TBW_OP_WRITE;
                if (tag_req_ready_in) begin
                    st_nxt.state = TBW_WR_WAIT;
                end
            end
            TBW_WR_WAIT: begin
                if (tag_resp_valid_in) begin
                    if (!tag_resp_ok_in) begin
                        st_nxt.outcome = `TBW_OUT_ERR_WRITE;
                        st_nxt.state   = TBW_FINISH;
                    end else if (st_r.left == 8'h01) begin
                        st_nxt.outcome = `TBW_OUT_OK;
                        st_nxt.state   = TBW_FINISH;
                    end else begin
                        st_nxt.left    = 8'(st_r.left - 8'h01);
                        st_nxt.blk     = next_blk;
                        st_nxt.tag_blk = next_blk;
                        st_nxt.gcnt    = 4'h0;
                        if (st_r.use_key && sector_of(next_blk) != sector_of(st_r.blk)) begin
                            st_nxt.state = TBW_AUTH_REQ;
                        end else begin
                            st_nxt.state = TBW_GATHER;
                        end
                    end
                end
            end
            TBW_FINISH: begin
                st_nxt.op = TBW_OP_NONE;
                if (st_r.outcome == `TBW_OUT_OK) begin
                    irq_set[`TBW_IRQ_DONE] = 1'b1;
                end else begin
                    irq_set[`TBW_IRQ_ERR] = 1'b1;
                end
                st_nxt.state = TBW_IDLE;
            end
            default: begin
                st_nxt.state = TBW_IDLE;
                st_nxt.op    = TBW_OP_NONE;
            end
        endcase

        // a new event wins over a clear in the same cycle
        st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r         <= '0;
            st_r.state   <= TBW_IDLE;
            st_r.op      <= TBW_OP_NONE;
            st_r.outcome <= `TBW_OUT_OK;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out     = st_r.rd_data;
    assign tag_req_valid_out = (st_r.state == TBW_AUTH_REQ) || (st_r.state == TBW_WR_REQ);
    assign tag_op_out        = st_r.op;
    assign tag_block_out     = st_r.tag_blk;
    assign tag_key_out       = st_r.tag_key;
    assign tag_key_b_out     = st_r.tag_key_b;
    assign tag_data_out      = st_r.data;
    assign busy_out          = (st_r.state != TBW_IDLE);
    assign irq_out           = |(st_r.irq_stat & st_r.irq_en);

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    logic start_ok;
    assign start_ok = (st_r.state == TBW_IDLE) && cmd_wr && reg_wdata_in == `TBW_CMD_WRITE
                      && st_r.args[`TBW_ARG_COUNT] != 8'h00;

    AST_CMD_START: assert property (start_ok |=> busy_out && st_r.outcome == `TBW_OUT_BUSY)
        else $error("write command did not start");
    AST_AUTH_FIRST: assert property (start_ok && reg_wdata_in == `TBW_CMD_WRITE
        && st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_USE_BIT] |=> st_r.state == TBW_AUTH_REQ ##1 tag_op_out == TBW_OP_AUTH)
        else $error("first sector not authenticated");
    AST_NO_KEY_SKIP: assert property (start_ok && !st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_USE_BIT]
        |=> st_r.state == TBW_GATHER)
        else $error("authentication without key");
    AST_KEY_B: assert property (start_ok |=> tag_key_b_out == $past(st_r.args[`TBW_ARG_KEYSEL][`TBW_KEY_B_BIT]))
        else $error("key kind wrong");
    AST_AUTH_NEEDS_KEY: assert property (st_r.state == TBW_AUTH_REQ |-> st_r.use_key)
        else $error("authentication requested without a key");
    AST_KEY_ORDER: assert property (start_ok |=> tag_key_out[7:0] == $past(st_r.args[`TBW_ARG_KEY])
        && tag_key_out[47:40] == $past(st_r.args[`TBW_ARG_KEY + 4'h5]))
        else $error("key byte order wrong");
    AST_ABS_BLOCK: assert property (start_ok |=> tag_block_out == $past(st_r.args[`TBW_ARG_BLOCK]))
        else $error("first block index wrong");
    AST_AUTH_FAIL: assert property (st_r.state == TBW_AUTH_WAIT && tag_resp_valid_in && !tag_resp_ok_in
        |=> st_r.outcome == `TBW_OUT_ERR_AUTH ##1 st_r.state == TBW_IDLE && st_r.irq_stat[`TBW_IRQ_ERR])
        else $error("authentication failure not reported");
    AST_AUTH_FAIL_END: assert property (st_r.state == TBW_AUTH_WAIT && tag_resp_valid_in && !tag_resp_ok_in
        |=> !tag_req_valid_out ##1 !tag_req_valid_out && !busy_out)
        else $error("request issued after failed authentication");
    AST_REQ_HOLD: assert property (tag_req_valid_out && !tag_req_ready_in |=> tag_req_valid_out
        && $stable(tag_block_out) && $stable(tag_key_out) && $stable(tag_data_out))
        else $error("tag request changed before acceptance");
    AST_REAUTH: assert property (st_r.state == TBW_WR_WAIT && tag_resp_valid_in && tag_resp_ok_in
        && st_r.left != 8'h01 && st_r.use_key && sector_of(next_blk) != sector_of(st_r.blk)
        |=> st_r.state == TBW_AUTH_REQ && tag_block_out == $past(next_blk))
        else $error("sector change not authenticated");
    AST_NEXT_BLOCK: assert property (st_r.state == TBW_WR_WAIT && tag_resp_valid_in && tag_resp_ok_in
        && st_r.left != 8'h01 |=> st_r.left == $past(st_r.left) - 8'h01)
        else $error("block count not advanced");
    AST_SUCCESS: assert property (st_r.state == TBW_WR_WAIT && tag_resp_valid_in && tag_resp_ok_in
        && st_r.left == 8'h01 |=> st_r.outcome == `TBW_OUT_OK ##1 !busy_out && st_r.irq_stat[`TBW_IRQ_DONE])
        else $error("success not reported");
    AST_OUTCOME_READ: assert property (reg_rd_in && reg_addr_in == `TBW_REG_OUTCOME
        |=> reg_rdata_out == $past(st_r.outcome))
        else $error("outcome read data wrong");
    AST_WRITE_ERR: assert property (st_r.state == TBW_WR_WAIT && tag_resp_valid_in && !tag_resp_ok_in
        |=> st_r.outcome == `TBW_OUT_ERR_WRITE ##1 st_r.irq_stat[`TBW_IRQ_ERR])
        else $error("write failure not reported");
    AST_ZERO_COUNT: assert property (st_r.state == TBW_IDLE && cmd_wr && reg_wdata_in == `TBW_CMD_WRITE
        && st_r.args[`TBW_ARG_COUNT] == 8'h00 |=> !busy_out && st_r.outcome == `TBW_OUT_ERR_PARAM)
        else $error("zero block count not refused");
    AST_CONSEC: assert property (st_r.state == TBW_GATHER |=> st_r.ptr == 8'($past(st_r.ptr) + 8'h01))
        else $error("staging bytes not consecutive");
    AST_START_OFFSET: assert property (start_ok |=> st_r.ptr == $past(st_r.args[`TBW_ARG_OFFSET]))
        else $error("staging offset not used");
    AST_GATHER_FROM_ZERO: assert property ($rose(st_r.state == TBW_GATHER) |-> st_r.gcnt == 4'h0)
        else $error("gather did not start at byte zero");
    AST_GATHER_END: assert property (st_r.state == TBW_GATHER && st_r.gcnt == 4'(`TBW_BLOCK_BYTES - 1)
        |=> st_r.state == TBW_WR_REQ)
        else $error("gather did not end after a full block");
    AST_GATHER_STAY: assert property (st_r.state == TBW_GATHER && st_r.gcnt != 4'(`TBW_BLOCK_BYTES - 1)
        |=> st_r.state == TBW_GATHER)
        else $error("gather ended before a full block");

    COV_KEYED_WRITE: cover property (st_r.state == TBW_AUTH_WAIT && tag_resp_valid_in && tag_resp_ok_in);
    COV_REAUTH: cover property (st_r.state == TBW_WR_WAIT && tag_resp_valid_in && tag_resp_ok_in
        ##1 st_r.state == TBW_AUTH_REQ);
    COV_SUCCESS: cover property (st_r.state == TBW_FINISH && st_r.outcome == `TBW_OUT_OK);
    COV_AUTH_FAIL: cover property (st_r.state == TBW_FINISH && st_r.outcome == `TBW_OUT_ERR_AUTH);
    COV_WRITE_FAIL: cover property (st_r.state == TBW_FINISH && st_r.outcome == `TBW_OUT_ERR_WRITE);

endmodule

`default_nettype wire

//--- tb/tbw_tag_model.sv
// behavioural tag engine answering the sequencer's requests
`timescale 1ns/1ps
`default_nettype none

module tbw_tag_model (
    // clock
    input  wire logic       clk_in,
    // request from the sequencer
    input  wire logic       req_valid_in,
    input  wire logic [1:0] op_in,
    output logic            req_ready_out,
    // response to the sequencer
    output logic            resp_valid_out,
    output logic            resp_ok_out,
    // behaviour chosen by the bench
    input  wire logic       slow_in,
    input  wire logic       fail_auth_in,
    input  wire logic       fail_write_in
);
    logic ok;

    initial begin
        req_ready_out  = 1'b0;
        resp_valid_out = 1'b0;
        resp_ok_out    = 1'b0;
        forever begin
            @(posedge clk_in);
            if (req_valid_in === 1'b1) begin
                // ready never comes in the cycle valid rises, so op is settled
                if (slow_in) repeat (2) @(posedge clk_in);
                req_ready_out <= 1'b1;
                @(posedge clk_in);
                req_ready_out <= 1'b0;
                ok = (op_in == 2'h1) ? !fail_auth_in : !fail_write_in;
                if (slow_in) repeat (3) @(posedge clk_in);
                resp_valid_out <= 1'b1;
                resp_ok_out    <= ok;
                @(posedge clk_in);
                resp_valid_out <= 1'b0;
                // outside the pulse the result line carries the opposite value
                resp_ok_out    <= !ok;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/tbw_sequencer_tb_top.sv
// self-checking bench of the tag block write sequencer
`include "tbw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tbw_sequencer_tb_top;
    logic         clk_in, reset_in, reg_wr_in, reg_rd_in, busy_out, irq_out;
    logic [8:0]   reg_addr_in;
    logic [7:0]   reg_wdata_in, reg_rdata_out;
    logic         valid, ready, resp_valid, resp_ok, key_b, slow, fail_auth, fail_write;
    logic [1:0]   op;
    logic [7:0]   blk;
    logic [47:0]  key;
    logic [127:0] data;
    logic [7:0]   buf_m [256];
    logic [186:0] mon_q [$];
    int           seed = 85366;
    int           errors = 0;
    int           n_compared = 0;

    tbw_sequencer i_tbw_sequencer (
        .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .tag_req_valid_out(valid), .tag_req_ready_in(ready), .tag_op_out(op), .tag_block_out(blk),
        .tag_key_out(key), .tag_key_b_out(key_b), .tag_data_out(data), .tag_resp_valid_in(resp_valid),
        .tag_resp_ok_in(resp_ok), .busy_out(busy_out), .irq_out(irq_out));

    tbw_tag_model i_tbw_tag_model (
        .clk_in(clk_in), .req_valid_in(valid), .op_in(op), .req_ready_out(ready), .resp_valid_out(resp_valid),
        .resp_ok_out(resp_ok), .slow_in(slow), .fail_auth_in(fail_auth), .fail_write_in(fail_write));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // record every request at its acceptance edge
    always @(posedge clk_in) begin
        if (valid === 1'b1 && ready === 1'b1) mon_q.push_back({op, blk, key, key_b, data});
    end

    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        v = reg_rdata_out;
        @(posedge clk_in);
    endtask

    // small sectors of 4 blocks below 128, 16 blocks above
    function automatic logic [7:0] sect(input logic [7:0] b);
        return (b < 8'h80) ? {2'h0, b[7:2]} : 8'h40 + {5'h0, b[6:4]};
    endfunction

    task automatic run(input logic [7:0] cmd, b, c, o, s, input logic [47:0] k, input logic fa, fw,
                       input logic [7:0] exp_out);
        int           i;
        int           j;
        int           w;
        logic [7:0]   v;
        logic [7:0]   bb;
        logic [1:0]   en;
        logic [1:0]   st;
        logic [127:0] d;
        logic [186:0] m;
        fail_auth  <= fa;
        fail_write <= fw;
        slow       <= 1'($random(seed));
        en = 2'($random(seed));
        wr(`TBW_REG_IRQ_EN, {6'h0, en});
        wr(`TBW_REG_IRQ_CLR, 8'h03);
        chk(irq_out, 1'b0, "irq after clear");
        wr(`TBW_REG_ARG_BASE, b);
        wr(`TBW_REG_ARG_BASE + 9'h1, c);
        wr(`TBW_REG_ARG_BASE + 9'h2, o);
        wr(`TBW_REG_ARG_BASE + 9'h3, s);
        for (i = 0; i < 6; i++) wr(`TBW_REG_ARG_BASE + 9'(4 + i), k[8*i +: 8]);
        wr(`TBW_REG_CMD, cmd);
        if (cmd == `TBW_CMD_WRITE && c != 8'h00) begin
            rd(`TBW_REG_OUTCOME, v);
            chk(v, `TBW_OUT_BUSY, "outcome while running");
            rd(`TBW_REG_STATUS, v);
            chk(v, 8'h01, "status while running");
        end
        for (i = 0; i < 3000 && busy_out !== 1'b0; i++) @(posedge clk_in);
        if (i == 3000) begin
            chk(1'b1, 1'b0, "command never finished");
            report_and_stop();
        end
        rd(`TBW_REG_OUTCOME, v);
        chk(v, exp_out, "outcome code");
        st = (exp_out == `TBW_OUT_OK) ? 2'h1 : 2'h2;
        rd(`TBW_REG_IRQ_STAT, v);
        chk(v, {6'h0, st}, "irq status");
        chk(irq_out, |(en & st), "irq level");
        rd(`TBW_REG_IRQ_EN, v);
        chk(v, {6'h0, en}, "irq enable readback");
        rd(`TBW_REG_STATUS, v);
        chk(v, 8'h00, "status when done");
        if (exp_out == `TBW_OUT_OK) begin
            for (i = 0; i < c; i++) begin
                bb = b + 8'(i);
                if (s[`TBW_KEY_USE_BIT] && (i == 0 || sect(bb) != sect(bb - 8'h01))) begin
                    m = (mon_q.size() > 0) ? mon_q.pop_front() : '0;
                    chk(m[186:177], {2'h1, bb}, "auth request");
                    chk(m[176:128], {k, s[`TBW_KEY_B_BIT]}, "auth key");
                end
                for (j = 0; j < 16; j++) d[8*j +: 8] = buf_m[(o + 16*i + j) % 256];
                m = (mon_q.size() > 0) ? mon_q.pop_front() : '0;
                chk(m[186:177], {2'h2, bb}, "write request");
                chk(m[127:0], d, "block data");
            end
        end
        // leftover writes, or any leftover request after success
        w = 0;
        while (mon_q.size() > 0) begin
            m = mon_q.pop_front();
            w += (m[186:185] == 2'h2 || exp_out == `TBW_OUT_OK) ? 1 : 0;
        end
        chk(w, (exp_out == `TBW_OUT_ERR_WRITE) ? 1 : 0, "extra requests");
    endtask

    initial begin
        int         i;
        logic [7:0] v;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] o;
        reset_in     = 1'b1;
        reg_addr_in  = 9'h000;
        reg_wdata_in = 8'h00;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        slow         = 1'b0;
        fail_auth    = 1'b0;
        fail_write   = 1'b0;
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        rd(`TBW_REG_OUTCOME, v);
        chk(v, `TBW_OUT_OK, "outcome after reset");
        rd(9'h0f0, v);
        chk(v, 8'h00, "unmapped read");
        for (i = 0; i < 256; i++) begin
            buf_m[i] = 8'($random(seed));
            wr(9'h100 + 9'(i), buf_m[i]);
        end
        // sector changes between small sectors and from a small into a large one, then the whole buffer with the secondary key
        run(8'h03, 8'h7e, 8'h04, 8'h10, 8'h40, 48'h0123456789ab, 1'b0, 1'b0, `TBW_OUT_OK);
        run(8'h03, 8'h00, 8'h10, 8'h00, 8'hc0, 48'ha5a55a5a0ff0, 1'b0, 1'b0, `TBW_OUT_OK);
        run(8'h03, 8'hff, 8'h01, 8'hf0, 8'h00, 48'h0, 1'b0, 1'b0, `TBW_OUT_OK);
        run(8'h03, 8'h03, 8'h02, 8'h20, 8'h40, 48'h112233445566, 1'b1, 1'b0, `TBW_OUT_ERR_AUTH);
        run(8'h03, 8'h08, 8'h03, 8'h00, 8'h00, 48'h0, 1'b0, 1'b1, `TBW_OUT_ERR_WRITE);
        // zero count and a foreign command code are refused
        run(8'h03, 8'h08, 8'h00, 8'h00, 8'h00, 48'h0, 1'b0, 1'b0, `TBW_OUT_ERR_PARAM);
        run(8'h02, 8'h08, 8'h01, 8'h00, 8'h00, 48'h0, 1'b0, 1'b0, `TBW_OUT_ERR_CMD);
        for (i = 0; i < 12; i++) begin
            // nonzero count, data kept inside the buffer
            c = 8'(($random(seed) & 3) + 1);
            b = 8'({$random(seed)} % (257 - c));
            o = 8'({$random(seed)} % (257 - 16 * c));
            run(8'h03, b, c, o, 8'($random(seed)) & 8'hc0, 48'({$random(seed), $random(seed)}), 1'b0, 1'b0,
                `TBW_OUT_OK);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
